// >>> hw/suspend_filter.sv
// Notes on behaviour
// - suspend during program halts it, clears write enable; reads, register accesses, error clear, resume, reset only.
// - program suspend sets the program suspended flag.
// - after suspend, commands rejected until ready; host polls busy or waits.
// - resume clears its suspend flag; the operation restarts only once no suspend flag is left set.
// - time before suspend plus after resume never exceeds uninterrupted time.
// - all single, dual, quad reads allowed in either suspend.
// - double rate fast reads allowed in either suspend.
// - page writes and write enable allowed only during erase suspend.
// - status, function register reads and error clear allowed in suspend.
// - soft reset honoured only right after arm opcode; no-op allowed.
// - identification reads allowed in either suspend.
// - volatile read parameter writes and reads allowed in either suspend.
// - bank register read, volatile write, wide address enter/exit allowed.
// - sector lock, protection bit commands allowed only in erase suspend.
// - erase suspend sets erase suspended flag and clears write enable.
// - program suspended flag is bit 2, erase suspended bit 3.
// - ready within 100 us of suspend; resume to suspend gap 400 us.
`timescale 1ns/1ps
`default_nettype none

module suspend_filter #(
  parameter int SUSPEND_LATENCY_CYC = suspend_filter_pkg::SUSPEND_LATENCY_CYC,
  parameter int RESUME_GAP_CYC      = suspend_filter_pkg::RESUME_GAP_CYC
) (
  input  wire logic       ref_clk_in,          // 20 MHz clock
  input  wire logic       reset_in,            // sync reset, active high
  input  wire logic       chip_select_n_in,    // host chip select, low active
  input  wire logic       serial_clk_in,       // host serial clock
  input  wire logic [3:0] data_in,             // io lines, bit0 in single
  input  wire logic       quad_mode_in,        // four-bit opcode transfer
  input  wire logic       program_busy_in,     // array program running
  input  wire logic       erase_busy_in,       // array erase running
  output logic            array_halt_out,      // stop the array timer
  output logic            write_enable_clr_out,// clear write enable latch
  output logic            soft_reset_out,      // soft reset pulse
  output logic            cmd_accept_out,      // opcode may run, pulse
  output logic [7:0]      cmd_opcode_out,      // last opcode seen
  output logic [7:0]      function_flags_out,  // suspend flag bits
  output logic            write_in_progress_out// busy flag
);

  typedef struct packed {
    logic [2:0]  cs_sync;   // [0] first stage, read only by [1]
    logic [2:0]  sck_sync;
    logic [7:0]  d0_s1;
    logic [7:0]  d0_s2;
    logic [7:0]  shift;
    logic [3:0]  nbits;
    logic [7:0]  opcode;
    logic        got_op;
    logic        prog_susp;
    logic        erase_susp;
    logic        armed;
    logic [23:0] settle;
    logic [23:0] gap;
    logic        wel_clr;
    logic        accept;
    logic        sreset;
  } state_t;

  state_t st_reg, st_next;

  // allowed during any suspend
  function automatic logic allow_any(input logic [7:0] op);
    case (op)
      8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC, 8'h3B, 8'h3C,
      8'hEB, 8'hEC, 8'h6B, 8'h6C: allow_any = 1'b1;
      8'h0D, 8'h0E, 8'hBD, 8'hBE, 8'hED, 8'hEE:
        allow_any = 1'b1;
      8'h05, 8'h48, 8'h82: allow_any = 1'b1;
      8'h00, 8'h66, 8'h99: allow_any = 1'b1;
      8'h9F, 8'h90, 8'hAF, 8'hAB, 8'h4B, 8'h5A, 8'h78:
        allow_any = 1'b1;
      8'hC0, 8'h63, 8'h83, 8'h61, 8'h81: allow_any = 1'b1;
      8'h14, 8'h16, 8'hC8, 8'h17, 8'hC5, 8'hB7, 8'h29:
        allow_any = 1'b1;
      8'h7A, 8'h30: allow_any = 1'b1;
      default: allow_any = 1'b0;
    endcase
  endfunction : allow_any

  // allowed only while an erase is suspended
  function automatic logic allow_erase(input logic [7:0] op);
    case (op)
      8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E, 8'h06:
        allow_erase = 1'b1;
      8'h26, 8'h25, 8'h24, 8'hFA, 8'hE0, 8'hFB, 8'hE1, 8'hFC, 8'hE2:
        allow_erase = 1'b1;
      8'h75, 8'hB0: allow_erase = 1'b1;
      default: allow_erase = 1'b0;
    endcase
  endfunction : allow_erase

  function automatic logic is_op(input logic [7:0] op,
                                 input logic [7:0] a,
                                 input logic [7:0] b);
    is_op = (op == a) || (op == b);
  endfunction : is_op

  ////////////////////////////////////////////////////////////////////////
  logic       sck_rise;
  logic       cs_low;
  logic       cs_rise;
  logic       busy;
  logic       suspended;
  logic       allowed;
  logic [7:0] full_op;

  always_comb begin
    st_next = st_reg;
    st_next.cs_sync  = {st_reg.cs_sync[1:0], chip_select_n_in};
    st_next.sck_sync = {st_reg.sck_sync[1:0], serial_clk_in};
    st_next.d0_s1    = {4'h0, data_in};
    st_next.d0_s2    = st_reg.d0_s1;
    st_next.wel_clr  = 1'b0;
    st_next.accept   = 1'b0;
    st_next.sreset   = 1'b0;
    cs_low    = ~st_reg.cs_sync[1];
    cs_rise   = st_reg.cs_sync[1] & ~st_reg.cs_sync[2];
    sck_rise  = st_reg.sck_sync[1] & ~st_reg.sck_sync[2];
    busy      = st_reg.settle != 24'h000000;
    suspended = st_reg.prog_susp | st_reg.erase_susp;
    full_op   = st_reg.shift;
    // quad: upper nibble first, two clocks per opcode
    if (cs_low && sck_rise && !st_reg.got_op) begin
      if (quad_mode_in) begin
        full_op = {st_reg.shift[3:0], st_reg.d0_s2[3:0]};
        st_next.nbits = st_reg.nbits + 4'h4;
      end else begin
        full_op = {st_reg.shift[6:0], st_reg.d0_s2[0]};
        st_next.nbits = st_reg.nbits + 4'h1;
      end
      st_next.shift = full_op;
      if (st_next.nbits == 4'h8) begin
        st_next.opcode = full_op;
        st_next.got_op = 1'b1;
      end
    end
    if (st_reg.settle != 24'h000000)
      st_next.settle = st_reg.settle - 24'h000001;
    if (st_reg.gap != 24'h000000)
      st_next.gap = st_reg.gap - 24'h000001;
    allowed = !suspended || allow_any(st_reg.opcode) ||
              (st_reg.erase_susp && !st_reg.prog_susp &&
               allow_erase(st_reg.opcode));
    // opcode acts when the frame closes
    if (cs_rise && st_reg.got_op && !busy && allowed) begin
      if (is_op(st_reg.opcode, suspend_filter_pkg::SUSPEND_CMD_A,
                suspend_filter_pkg::SUSPEND_CMD_B)) begin
        if (st_reg.gap == 24'h000000 &&
            (program_busy_in || erase_busy_in)) begin
          st_next.prog_susp  = st_reg.prog_susp | program_busy_in;
          st_next.erase_susp = st_reg.erase_susp | erase_busy_in;
          st_next.wel_clr    = 1'b1;
          st_next.settle     = 24'(SUSPEND_LATENCY_CYC);
        end
      end else if (is_op(st_reg.opcode, suspend_filter_pkg::RESUME_CMD_A,
                         suspend_filter_pkg::RESUME_CMD_B)) begin
        // nested program inside erase suspend resumes first
        if (st_reg.prog_susp)
          st_next.prog_susp = 1'b0;
        else
          st_next.erase_susp = 1'b0;
        if (suspended)
          st_next.gap = 24'(RESUME_GAP_CYC);
      end else begin
        st_next.accept = 1'b1;
        if (st_reg.opcode == suspend_filter_pkg::SOFT_RESET_CMD &&
            st_reg.armed)
          st_next.sreset = 1'b1;
      end
      st_next.armed = st_reg.opcode == suspend_filter_pkg::SOFT_RESET_ARM_CMD;
    end
    if (cs_rise) begin
      st_next.nbits  = suspend_filter_pkg::BITS_RESET;
      st_next.shift  = suspend_filter_pkg::SHIFT_RESET;
      st_next.got_op = 1'b0;
    end
    if (st_next.sreset) begin
      st_next.prog_susp  = 1'b0;
      st_next.erase_susp = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      st_reg <= '0;
      st_reg.cs_sync <= 3'h7;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // array timer is frozen, not reset, so elapsed time is kept
  assign array_halt_out        = st_reg.prog_susp | st_reg.erase_susp;
  assign write_enable_clr_out  = st_reg.wel_clr;
  assign soft_reset_out        = st_reg.sreset;
  assign cmd_accept_out        = st_reg.accept;
  assign cmd_opcode_out        = st_reg.opcode;
  assign write_in_progress_out = st_reg.settle != 24'h000000;
  always_comb begin
    function_flags_out = 8'h00;
    function_flags_out[suspend_filter_pkg::PROGRAM_SUSPENDED_BIT] =
      st_reg.prog_susp;
    function_flags_out[suspend_filter_pkg::ERASE_SUSPENDED_BIT] =
      st_reg.erase_susp;
  end

  ////////////////////////////////////////////////////////////////////////
  AST_WEL_ON_SUSPEND: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    $rose(st_reg.prog_susp) |-> write_enable_clr_out)
    else $error("write enable not cleared on program suspend");
  AST_PROGRAM_SUSPENDED_FLAG_BIT: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    function_flags_out[2] == st_reg.prog_susp)
    else $error("program flag misplaced");
  AST_ERASE_SUSPENDED_FLAG_WEL: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $rose(function_flags_out[3]) |-> write_enable_clr_out)
    else $error("erase suspend without write enable clear");
  AST_BUSY_AFTER_SUSP: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    $rose(function_flags_out[2]) |-> write_in_progress_out[*8])
    else $error("busy not held after suspend");
  AST_NO_ACCEPT_BUSY: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    write_in_progress_out |=> !cmd_accept_out || $past(busy) == 1'b0)
    else $error("command accepted while busy");
  AST_NO_WRITE_ENABLE_CMD_PROGRAM_SUSPENDED_FLAG: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    cmd_accept_out && st_reg.prog_susp |->
      cmd_opcode_out != suspend_filter_pkg::WRITE_ENABLE_CMD)
    else $error("write enable accepted in program suspend");
  AST_RESET_NEEDS_ARM: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    soft_reset_out |-> $past(st_reg.armed))
    else $error("soft reset without arm");
  AST_HALT_FOLLOWS: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    array_halt_out == (function_flags_out[2] | function_flags_out[3]))
    else $error("halt does not match flags");

  // a fresh suspend clears write enable, then holds busy while it settles
  sequence susp_pulse_s;
    write_enable_clr_out && write_in_progress_out;
  endsequence
  sequence susp_settle_s;
    write_in_progress_out [*8];
  endsequence
  AST_SUSPEND_STEPS: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    $rose(array_halt_out) |-> susp_pulse_s ##1 susp_settle_s)
    else $error("suspend did not clear write enable then settle");
  // flags sampled one cycle back, since a soft reset may clear them
  AST_PROGRAM_SUSPENDED_FLAG_FILTER: assert property (@(posedge ref_clk_in)
    disable iff (reset_in)
    cmd_accept_out && $past(st_reg.prog_susp) |->
      allow_any(cmd_opcode_out))
    else $error("unlisted command accepted in program suspend");

endmodule : suspend_filter

`default_nettype wire

// >>> hw/suspend_filter_pkg.sv
`default_nettype none
package suspend_filter_pkg;

  // opcodes
  localparam logic [7:0] SUSPEND_CMD_A      = 8'h75;
  localparam logic [7:0] SUSPEND_CMD_B      = 8'hB0;
  localparam logic [7:0] RESUME_CMD_A       = 8'h7A;
  localparam logic [7:0] RESUME_CMD_B       = 8'h30;
  localparam logic [7:0] SOFT_RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] SOFT_RESET_CMD     = 8'h99;
  localparam logic [7:0] WRITE_ENABLE_CMD   = 8'h06;

  // function register flag positions
  localparam int PROGRAM_SUSPENDED_BIT = 2;
  localparam int ERASE_SUSPENDED_BIT   = 3;

  // timing
  localparam int CLK_PERIOD_NS       = 50;
  localparam int SUSPEND_LATENCY_US  = 100;
  localparam int RESUME_GAP_US       = 400;
  localparam int SUSPEND_LATENCY_CYC =
    (SUSPEND_LATENCY_US * 1000) / CLK_PERIOD_NS;
  localparam int RESUME_GAP_CYC =
    (RESUME_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0]  SHIFT_RESET = 8'h00;
  localparam logic [3:0]  BITS_RESET  = 4'h0;
  localparam logic [23:0] TIME_RESET  = 24'h000000;

endpackage : suspend_filter_pkg
`default_nettype wire

// >>> verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic       cs_n_out, // chip select, low active
  output logic       sck_out,  // serial clock, still outside frames
  output logic [3:0] io_out    // io lines
);
  initial begin
    cs_n_out = 1'b1;
    sck_out  = 1'b0;
    io_out   = 4'h0;
  end
  // one opcode a frame, msb or upper nibble first
  task automatic send(input logic [7:0] op, input logic q);
    int n;
    n = q ? 2 : 8;
    cs_n_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      io_out = q ? (i == 0 ? op[7:4] : op[3:0]) : {3'h0, op[7-i]};
      #200 sck_out = 1'b1;
      #200 sck_out = 1'b0;
    end
    #200 cs_n_out = 1'b1;
    // released lines must not look like the last bit
    io_out = ~io_out;
  endtask : send
endmodule : spi_host_model
`default_nettype wire

// >>> verif/test_flash_suspend_resume_filter.sv
`timescale 1ns/1ps
`default_nettype none
module test_flash_suspend_resume_filter;
  localparam int LAT = 200;
  localparam int GAP = 400;
  localparam logic [7:0] PS = 8'h01 << suspend_filter_pkg::PROGRAM_SUSPENDED_BIT;
  localparam logic [7:0] ES = 8'h01 << suspend_filter_pkg::ERASE_SUSPENDED_BIT;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       quad = 1'b0;
  logic       pbusy = 1'b0;
  logic       ebusy = 1'b0;
  logic       cs_n, sck, halt, wec, srst, acc, write_in_progress_flag;
  logic [3:0] io;
  logic [7:0] opc, flags;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;
  int         acc_n = 0;
  int         wec_n = 0;
  int         srst_n = 0;
  logic [7:0] both_ok [41] = '{8'h03, 8'h13, 8'h0B, 8'h0C, 8'hBB, 8'hBC,
    8'h3B, 8'h3C, 8'hEB, 8'hEC, 8'h6B, 8'h6C, 8'h0D, 8'h0E, 8'hBD, 8'hBE,
    8'hED, 8'hEE, 8'h05, 8'h48, 8'h82, 8'hAB, 8'hC0, 8'h63, 8'h83, 8'h61,
    8'h81, 8'h9F, 8'h90, 8'hAF, 8'h4B, 8'h5A, 8'h00, 8'h78, 8'h14, 8'h16,
    8'hC8, 8'h17, 8'hC5, 8'hB7, 8'h29};
  logic [7:0] ers_ok [16] = '{8'h02, 8'h12, 8'h32, 8'h38, 8'h34, 8'h3E,
    8'h06, 8'h26, 8'h25, 8'h24, 8'hFA, 8'hE0, 8'hFB, 8'hE1, 8'hFC, 8'hE2};
  logic [7:0] bad [5] = '{8'hC7, 8'h20, 8'hD8, 8'h75, 8'hB0};

  always #25 clk = ~clk;

  spi_host_model spi_host_model_i (.cs_n_out(cs_n), .sck_out(sck),
    .io_out(io));

  suspend_filter #(.SUSPEND_LATENCY_CYC(LAT), .RESUME_GAP_CYC(GAP))
  suspend_filter_i (.ref_clk_in(clk), .reset_in(rst),
    .chip_select_n_in(cs_n), .serial_clk_in(sck), .data_in(io),
    .quad_mode_in(quad), .program_busy_in(pbusy), .erase_busy_in(ebusy),
    .array_halt_out(halt), .write_enable_clr_out(wec),
    .soft_reset_out(srst), .cmd_accept_out(acc), .cmd_opcode_out(opc),
    .function_flags_out(flags), .write_in_progress_out(write_in_progress_flag));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  // pulses last one cycle, so they are counted here, not sampled later
  always @(posedge clk) begin
    cyc++;
    if (acc === 1'b1) acc_n++;
    if (wec === 1'b1) wec_n++;
    if (srst === 1'b1) srst_n++;
    if (cyc == 12000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic ok, input logic [7:0] tag);
    n_tests++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("ERROR %0t mismatch near %h", $time, tag);
    end
  endtask : check

  // expected pulse counts; a negative accept count means not judged
  task automatic frame(input logic [7:0] op, input logic q, input int a,
                       input int w, input int r);
    int a0, w0, r0;
    a0 = acc_n;
    w0 = wec_n;
    r0 = srst_n;
    quad = q;
    spi_host_model_i.send(op, q);
    repeat (8) @(negedge clk);
    check((a < 0 || acc_n - a0 == a) && (a != 1 || opc === op) &&
          wec_n - w0 == w && srst_n - r0 == r, op);
  endtask : frame

  task automatic flg(input logic [7:0] f);
    check(flags === f && halt === (f != 8'h00), 8'hF0);
  endtask : flg

  task automatic wait_ready();
    int n;
    n = 0;
    while (write_in_progress_flag === 1'b1 && n < LAT + 50) begin
      @(negedge clk);
      n++;
    end
    check(n > LAT - 60 && n <= LAT, 8'hEE);
  endtask : wait_ready

  task automatic lists(input int er);
    foreach (both_ok[i]) frame(both_ok[i], 1'b1, 1, 0, 0);
    foreach (ers_ok[i]) frame(ers_ok[i], 1'b1, er, 0, 0);
  endtask : lists

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    flg(8'h00);
    frame(8'h75, 1'b0, 0, 0, 0);
    pbusy = 1'b1;
    frame(8'h75, 1'b0, 0, 1, 0);
    flg(PS);
    check(write_in_progress_flag === 1'b1, 8'hEE);
    frame(8'h03, 1'b1, 0, 0, 0);
    wait_ready();
    lists(0);
    foreach (bad[i]) frame(bad[i], 1'b1, 0, 0, 0);
    flg(PS);
    frame(8'h7A, 1'b1, 0, 0, 0);
    flg(8'h00);
    check(write_in_progress_flag === 1'b0, 8'hEE);
    pbusy = 1'b0;
    ebusy = 1'b1;
    frame(8'hB0, 1'b1, 0, 0, 0);
    repeat (GAP) @(negedge clk);
    frame(8'hB0, 1'b1, 0, 1, 0);
    flg(ES);
    wait_ready();
    lists(1);
    // program suspended inside the erase suspend
    ebusy = 1'b0;
    pbusy = 1'b1;
    frame(8'h75, 1'b1, 0, 1, 0);
    wait_ready();
    frame(8'h06, 1'b1, 0, 0, 0);
    flg(PS | ES);
    frame(8'h7A, 1'b1, 0, 0, 0);
    flg(ES);
    pbusy = 1'b0;
    ebusy = 1'b1;
    frame(8'h30, 1'b0, 0, 0, 0);
    flg(8'h00);
    repeat (GAP) @(negedge clk);
    frame(8'h75, 1'b0, 0, 1, 0);
    wait_ready();
    frame(8'h99, 1'b1, -1, 0, 0);
    frame(8'h66, 1'b1, -1, 0, 0);
    frame(8'h03, 1'b1, 1, 0, 0);
    frame(8'h99, 1'b1, -1, 0, 0);
    flg(ES);
    frame(8'h66, 1'b1, -1, 0, 0);
    frame(8'h99, 1'b1, -1, 0, 1);
    flg(8'h00);
    // reset in the middle of an erase suspend
    frame(8'hB0, 1'b1, 0, 1, 0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    check(flags === 8'h00 && halt === 1'b0 && write_in_progress_flag === 1'b0, 8'h5E);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    frame(8'h48, 1'b0, 1, 0, 0);
    flg(8'h00);
    give_verdict();
  end
endmodule : test_flash_suspend_resume_filter
`default_nettype wire
